// *** logic/iopab_port.sv ***
// Port A output type and pin functions, port B direction, data and readback.
`timescale 1ns/1ns
module iopab_port #(
	parameter int unsigned PB_W = iopab_pkg::PB_PINS
) (
	input  wire logic                          clk_sys,
	input  wire logic                          nrst,
	input  wire logic [iopab_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [iopab_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [iopab_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic [iopab_pkg::PA_PINS-1:0] pa_in,
	output logic      [iopab_pkg::PA_PINS-1:0] pa_out,
	output logic      [iopab_pkg::PA_PINS-1:0] pa_oe,
	output logic      [iopab_pkg::PA_PINS-1:0] pa_pullup,
	input  wire logic [PB_W-1:0]               pb_in,
	output logic      [PB_W-1:0]               pb_out,
	output logic      [PB_W-1:0]               pb_oe,
	input  wire logic [iopab_pkg::PA_PINS-1:0] shutdown_in_enable,
	input  wire logic                          clock_pin_mode_hi,
	input  wire logic                          clock_pin_mode_lo,
	input  wire logic                          serial2_sync_mode,
	input  wire logic                          rx_path_on,
	input  wire logic                          tx_path_on,
	input  wire logic                          serial2_clock_out,
	input  wire logic                          serial2_tx_data,
	output logic                               serial2_clock_in,
	output logic                               serial2_rx_data,
	output logic      [iopab_pkg::PA_PINS-1:0] shutdown_in
);
	import iopab_pkg::*;

	if (PB_W == 0 || PB_W > DATA_W) begin : g_bad_width
		$error("Port B width must be between 1 and the register width.");
	end

	typedef struct packed {
		logic [PA_PINS-1:0] pa_dir;
		logic [PA_PINS-1:0] pa_data;
		logic [PA_PINS-1:0] pa_pcr;
		logic [PA_PINS-1:0] pa_type;
		logic [PB_W-1:0]    pb_dir;
		logic [PB_W-1:0]    pb_data;
		logic [DATA_W-1:0]  rdata;
		logic [PA_PINS-1:0] pa_out;
		logic [PA_PINS-1:0] pa_oe;
		logic [PA_PINS-1:0] pa_pu;
		logic [PB_W-1:0]    pb_out;
		logic [PB_W-1:0]    pb_oe;
		logic               sclk_in;
		logic               rx_data;
		logic [PA_PINS-1:0] sd_level;
	} iopab_state_s;

	iopab_state_s state_reg;
	iopab_state_s state_next;

	logic [PA_PINS-1:0] pa_pin;
	logic [PB_W-1:0]    pb_pin;
	iopab_a3_fn_e       a3_fn;
	logic [PA_PINS-1:0] pa_is_out;
	logic [PA_PINS-1:0] pa_val;
	logic [PA_PINS-1:0] pa_cell_out;
	logic [PA_PINS-1:0] pa_cell_oe;
	logic [PA_PINS-1:0] pa_cell_pu;
	logic [PB_W-1:0]    pb_cell_out;
	logic [PB_W-1:0]    pb_cell_oe;

	// Readback mixes stored data for outputs and pin levels for inputs.
	function automatic logic [DATA_W-1:0] iopab_readback(
		input logic [DATA_W-1:0] data,
		input logic [DATA_W-1:0] dir,
		input logic [DATA_W-1:0] pin
	);
		return (data & dir) | (pin & ~dir);
	endfunction : iopab_readback

	iopab_sync #(
		.W (PA_PINS)
	) u_sync_pa (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.d       (pa_in),
		.q       (pa_pin)
	);

	iopab_sync #(
		.W (PB_W)
	) u_sync_pb (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.d       (pb_in),
		.q       (pb_pin)
	);

	// Mode inputs come from logic on this clock and are used as levels each cycle.
	always_comb begin
		if (shutdown_in_enable[3]) begin
			a3_fn = IOPAB_A3_SHUTDOWN;
		end else if (clock_pin_mode_hi) begin
			a3_fn = IOPAB_A3_SCLK_IN;
		end else if (serial2_sync_mode || clock_pin_mode_lo) begin
			a3_fn = IOPAB_A3_SCLK_OUT;
		end else begin
			a3_fn = IOPAB_A3_GPIO;
		end
	end

	always_comb begin
		case (a3_fn)
			IOPAB_A3_SHUTDOWN: begin
				pa_is_out[3] = 1'b0;
				pa_val[3]    = state_reg.pa_data[3];
			end
			IOPAB_A3_SCLK_IN: begin
				pa_is_out[3] = 1'b0;
				pa_val[3]    = state_reg.pa_data[3];
			end
			IOPAB_A3_SCLK_OUT: begin
				pa_is_out[3] = 1'b1;
				pa_val[3]    = serial2_clock_out;
			end
			default: begin
				pa_is_out[3] = state_reg.pa_dir[3];
				pa_val[3]    = state_reg.pa_data[3];
			end
		endcase
		// Pin A2 never drives for the serial channel, only receives.
		pa_is_out[2] = !shutdown_in_enable[2] && !rx_path_on && state_reg.pa_dir[2];
		pa_val[2]    = state_reg.pa_data[2];
		if (shutdown_in_enable[1]) begin
			pa_is_out[1] = 1'b0;
			pa_val[1]    = state_reg.pa_data[1];
		end else if (tx_path_on) begin
			pa_is_out[1] = 1'b1;
			pa_val[1]    = serial2_tx_data;
		end else begin
			pa_is_out[1] = state_reg.pa_dir[1];
			pa_val[1]    = state_reg.pa_data[1];
		end
		pa_is_out[0] = !shutdown_in_enable[0] && state_reg.pa_dir[0];
		pa_val[0]    = state_reg.pa_data[0];
	end

	for (genvar i = 0; i < PA_PINS; i++) begin : g_pa_cell
		iopab_pin_cell u_cell (
			.is_output  (pa_is_out[i]),
			.data       (pa_val[i]),
			.open_drain (state_reg.pa_type[i]),
			.pullup_req (state_reg.pa_pcr[i]),
			.pin_out    (pa_cell_out[i]),
			.pin_oe     (pa_cell_oe[i]),
			.pullup_on  (pa_cell_pu[i])
		);
	end

	// Port B output type and pull-up live elsewhere, so the cells run push-pull here.
	for (genvar i = 0; i < PB_W; i++) begin : g_pb_cell
		iopab_pin_cell u_cell (
			.is_output  (state_reg.pb_dir[i]),
			.data       (state_reg.pb_data[i]),
			.open_drain (1'b0),
			.pullup_req (1'b0),
			.pin_out    (pb_cell_out[i]),
			.pin_oe     (pb_cell_oe[i]),
			.pullup_on  ()
		);
	end

	always_comb begin
		state_next = state_reg;
		if (reg_wr) begin
			if (reg_addr == OFS_PA_DIRECTION) begin
				state_next.pa_dir = reg_wdata[PA_PINS-1:0];
			end else if (reg_addr == OFS_PA_OUTPUT_DATA) begin
				state_next.pa_data = reg_wdata[PA_PINS-1:0];
			end else if (reg_addr == OFS_PA_PULLUP_CTRL) begin
				state_next.pa_pcr = reg_wdata[PA_PINS-1:0];
			end else if (reg_addr == OFS_PA_OUTPUT_TYPE) begin
				state_next.pa_type = reg_wdata[PA_PINS-1:0];
			end else if (reg_addr == OFS_PB_DIRECTION) begin
				state_next.pb_dir = reg_wdata[PB_W-1:0];
			end else if (reg_addr == OFS_PB_OUTPUT_DATA) begin
				state_next.pb_data = reg_wdata[PB_W-1:0];
			end
			// Writes to either pin-state offset are dropped.
		end
		// Read data stands for one cycle only and is zero otherwise.
		state_next.rdata = READ_UNDEF;
		if (reg_rd) begin
			if (reg_addr == OFS_PA_OUTPUT_DATA) begin
				state_next.rdata = DATA_W'(state_reg.pa_data);
			end else if (reg_addr == OFS_PA_PIN_STATE) begin
				state_next.rdata = iopab_readback(DATA_W'(state_reg.pa_data),
					DATA_W'(state_reg.pa_dir), DATA_W'(pa_pin));
			end else if (reg_addr == OFS_PA_PULLUP_CTRL) begin
				state_next.rdata = DATA_W'(state_reg.pa_pcr);
			end else if (reg_addr == OFS_PA_OUTPUT_TYPE) begin
				state_next.rdata = DATA_W'(state_reg.pa_type);
			end else if (reg_addr == OFS_PB_OUTPUT_DATA) begin
				state_next.rdata = DATA_W'(state_reg.pb_data);
			end else if (reg_addr == OFS_PB_PIN_STATE) begin
				state_next.rdata = iopab_readback(DATA_W'(state_reg.pb_data),
					DATA_W'(state_reg.pb_dir), DATA_W'(pb_pin));
			end else begin
				state_next.rdata = READ_UNDEF;
			end
		end
		state_next.pa_out  = pa_cell_out;
		state_next.pa_oe   = pa_cell_oe;
		state_next.pa_pu   = pa_cell_pu;
		state_next.pb_out  = pb_cell_out;
		state_next.pb_oe   = pb_cell_oe;
		state_next.sclk_in = (a3_fn == IOPAB_A3_SCLK_IN) ? pa_pin[3] : IDLE_LEVEL;
		state_next.rx_data = (!shutdown_in_enable[2] && rx_path_on) ? pa_pin[2] : IDLE_LEVEL;
		for (int i = 0; i < PA_PINS; i++) begin
			state_next.sd_level[i] = shutdown_in_enable[i] ? pa_pin[i] : IDLE_LEVEL;
		end
	end

	// Reset leaves every pin an undriven input until software sets a direction, except A1 and A3 when a serial mode drives them.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg         <= '0;
			state_reg.pa_dir  <= RST_PA_NIBBLE;
			state_reg.pa_type <= RST_PA_NIBBLE;
			state_reg.pb_dir  <= PB_W'(RST_BYTE);
			state_reg.pb_data <= PB_W'(RST_BYTE);
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata        = state_reg.rdata;
	assign pa_out           = state_reg.pa_out;
	assign pa_oe            = state_reg.pa_oe;
	assign pa_pullup        = state_reg.pa_pu;
	assign pb_out           = state_reg.pb_out;
	assign pb_oe            = state_reg.pb_oe;
	assign serial2_clock_in = state_reg.sclk_in;
	assign serial2_rx_data  = state_reg.rx_data;
	assign shutdown_in      = state_reg.sd_level;

	a_pb_dir_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
		reg_wr && reg_addr == OFS_PB_DIRECTION |=> ##1 pb_oe == $past(reg_wdata[PB_W-1:0], 2))
		else $error("Port B enables do not follow the written direction.");

	a_pb_data_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
		reg_wr && reg_addr == OFS_PB_OUTPUT_DATA |=> ##1 pb_out == $past(reg_wdata[PB_W-1:0], 2))
		else $error("Port B pins do not follow the written data.");

	a_pb_dir_hidden: assert property (@(posedge clk_sys) disable iff (!nrst)
		reg_rd && reg_addr == OFS_PB_DIRECTION |=> reg_rdata == READ_UNDEF)
		else $error("Port B direction read shows a stored value.");

	a_pb_state_read: assert property (@(posedge clk_sys) disable iff (!nrst)
		reg_rd && reg_addr == OFS_PB_PIN_STATE |=> reg_rdata[PB_W-1:0] ==
		$past((state_reg.pb_data & state_reg.pb_dir) | (pb_pin & ~state_reg.pb_dir)))
		else $error("Port B pin state read returns the wrong mix.");

	a_pb_state_wr: assert property (@(posedge clk_sys) disable iff (!nrst)
		reg_wr && reg_addr == OFS_PB_PIN_STATE |=> $stable(state_reg.pb_data)
		&& $stable(state_reg.pb_dir))
		else $error("Write to port B pin state changed a register.");

	a_pa_type_read: assert property (@(posedge clk_sys) disable iff (!nrst)
		reg_rd && reg_addr == OFS_PA_OUTPUT_TYPE |=> reg_rdata[DATA_W-1:PA_PINS] == '0)
		else $error("Reserved output type bits read nonzero.");

	a_pa_open_drain: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg.pa_type[0] && pa_is_out[0] |=> !pa_out[0] && !pa_pullup[0]
		&& pa_oe[0] == !$past(pa_val[0]))
		else $error("Open-drain pin A0 drives high or keeps its pull-up.");

	a_pa_push_pull: assert property (@(posedge clk_sys) disable iff (!nrst)
		!state_reg.pa_type[1] && pa_is_out[1] |=> pa_oe[1] && pa_out[1] == $past(pa_val[1]))
		else $error("Push-pull pin A1 is not driven.");

	a_pa3_shutdown: assert property (@(posedge clk_sys) disable iff (!nrst)
		shutdown_in_enable[3] |=> !pa_oe[3] && shutdown_in[3] == $past(pa_pin[3]))
		else $error("Pin A3 drives while it is a shutdown input.");

	a_pa3_clock_out: assert property (@(posedge clk_sys) disable iff (!nrst)
		!shutdown_in_enable[3] && !clock_pin_mode_hi && clock_pin_mode_lo
		&& !state_reg.pa_type[3] |=> pa_oe[3] && pa_out[3] == $past(serial2_clock_out))
		else $error("Pin A3 does not carry the serial clock out.");

	a_pa_pullup_on: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg.pa_pcr[0] && !pa_is_out[0] |=> pa_pullup[0])
		else $error("Input pin A0 lacks its requested pull-up.");

	a_pa2_rx_input: assert property (@(posedge clk_sys) disable iff (!nrst)
		!shutdown_in_enable[2] && rx_path_on
		|=> !pa_oe[2] && serial2_rx_data == $past(pa_pin[2]))
		else $error("Pin A2 drives or loses its level while the receiver owns it.");

	a_pa1_tx_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
		!shutdown_in_enable[1] && tx_path_on && !state_reg.pa_type[1]
		|=> pa_oe[1] && pa_out[1] == $past(serial2_tx_data))
		else $error("Pin A1 does not carry the transmit data.");

	a_pa0_shutdown: assert property (@(posedge clk_sys) disable iff (!nrst)
		shutdown_in_enable[0]
		|=> !pa_oe[0] && shutdown_in[0] == $past(pa_pin[0]))
		else $error("Pin A0 drives while it is a shutdown input.");

	a_pa3_clock_in: assert property (@(posedge clk_sys) disable iff (!nrst)
		!shutdown_in_enable[3] && clock_pin_mode_hi
		|=> !pa_oe[3] && serial2_clock_in == $past(pa_pin[3]))
		else $error("Pin A3 does not pass the serial clock in.");

	a_pa_state_read: assert property (@(posedge clk_sys) disable iff (!nrst)
		reg_rd && reg_addr == OFS_PA_PIN_STATE |=> reg_rdata[DATA_W-1:PA_PINS] == '0
		&& reg_rdata[2] == $past(state_reg.pa_dir[2] ? state_reg.pa_data[2] : pa_pin[2]))
		else $error("Port A pin state read returns the wrong level.");

	c_pb_state_read: cover property (@(posedge clk_sys) disable iff (!nrst)
		reg_rd && reg_addr == OFS_PB_PIN_STATE && state_reg.pb_dir != '0);
	c_pa3_clock_out: cover property (@(posedge clk_sys) disable iff (!nrst)
		a3_fn == IOPAB_A3_SCLK_OUT ##1 pa_oe[3]);
	c_pa_open_drain: cover property (@(posedge clk_sys) disable iff (!nrst)
		state_reg.pa_type[0] && pa_is_out[0] && pa_val[0]);
	c_pa1_tx: cover property (@(posedge clk_sys) disable iff (!nrst)
		tx_path_on && !shutdown_in_enable[1]);

endmodule : iopab_port

// *** inc/iopab_pkg.sv ***
// Shared constants and types for the port A and port B pin control block.
package iopab_pkg;

	localparam int unsigned DATA_W  = 8;
	localparam int unsigned ADDR_W  = 3;
	localparam int unsigned PA_PINS = 4;
	localparam int unsigned PB_PINS = 8;

	// Register offsets on the plain register port.
	localparam logic [ADDR_W-1:0] OFS_PA_DIRECTION   = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_PA_OUTPUT_DATA = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_PA_PIN_STATE   = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_PA_PULLUP_CTRL = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_PA_OUTPUT_TYPE = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_PB_DIRECTION   = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_PB_OUTPUT_DATA = 3'h6;
	localparam logic [ADDR_W-1:0] OFS_PB_PIN_STATE   = 3'h7;

	// Values after reset.
	localparam logic [PA_PINS-1:0] RST_PA_NIBBLE = 4'h0;
	localparam logic [DATA_W-1:0]  RST_BYTE      = 8'h00;

	// Value returned for reserved bits and for write-only registers.
	localparam logic [DATA_W-1:0]  READ_UNDEF    = 8'h00;

	// Level shown to the serial and shutdown blocks when a pin is not theirs.
	localparam logic               IDLE_LEVEL    = 1'b1;

	// Pin A3 function choice, in priority order.
	typedef enum logic [1:0] {
		IOPAB_A3_GPIO     = 2'b00,
		IOPAB_A3_SCLK_OUT = 2'b01,
		IOPAB_A3_SCLK_IN  = 2'b10,
		IOPAB_A3_SHUTDOWN = 2'b11
	} iopab_a3_fn_e;

endpackage : iopab_pkg

// *** logic/iopab_sync.sv ***
// Two-flop synchroniser for pin levels entering the system clock domain.
`timescale 1ns/1ns
module iopab_sync #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	import iopab_pkg::*;

	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} iopab_sync_s;

	iopab_sync_s sync_reg;
	iopab_sync_s sync_next;

	// The first stage feeds only the second, so metastability never reaches logic.
	always_comb begin
		sync_next        = sync_reg;
		sync_next.stage1 = d;
		sync_next.stage2 = sync_reg.stage1;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign q = sync_reg.stage2;

endmodule : iopab_sync

// *** logic/iopab_pin_cell.sv ***
// Output driver and pull-up decision for one pin.
`timescale 1ns/1ns
module iopab_pin_cell (
	input  wire logic is_output,
	input  wire logic data,
	input  wire logic open_drain,
	input  wire logic pullup_req,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      pullup_on
);
	import iopab_pkg::*;

	always_comb begin
		// Open drain pulls low for 0 and lets go for 1; push-pull always drives.
		pin_out   = open_drain ? 1'b0 : data;
		pin_oe    = is_output && (!open_drain || !data);
		// A pull-up only serves an input pin, so an open-drain output has it off.
		pullup_on = !is_output && pullup_req;
	end

endmodule : iopab_pin_cell

// *** tb/iopab_board.sv ***
// Board model that settles the level of each port pin from every party that drives it.
`timescale 1ns/1ns
module iopab_board #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic [W-1:0] dev_out,
	input  wire logic [W-1:0] dev_oe,
	input  wire logic [W-1:0] pull_en,
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_en,
	output logic      [W-1:0] level
);
	logic [W-1:0] noise_reg = '0;

	// A floating pin flips every cycle, so no check can lean on the simulator's own choice.
	always @(posedge clk_sys) begin
		noise_reg <= ~noise_reg;
	end

	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (dev_oe[i]) begin
				level[i] = dev_out[i];
			end else if (ext_en[i]) begin
				level[i] = ext_val[i];
			end else if (pull_en[i]) begin
				level[i] = 1'b1;
			end else begin
				level[i] = noise_reg[i];
			end
		end
	end
endmodule : iopab_board

// *** tb/tb.sv ***
// Self-checking testbench for the port A and port B pin control block.
`timescale 1ns/1ns
module tb;
	import iopab_pkg::*;

	logic             clk_sys = 1'b0;
	logic             nrst;
	logic [2:0]       reg_addr;
	logic [7:0]       reg_wdata, reg_rdata;
	logic             reg_wr, reg_rd, smp, rd_d = 1'b0, smp_d = 1'b0;
	logic [3:0]       pa_in, pa_out, pa_oe, pa_pullup, sd_en, sd_in, ext_a, ext_a_en;
	logic [7:0]       pb_in, pb_out, pb_oe, ext_b;
	logic             ck_hi, ck_lo, sync_m, rx_on, tx_on, s_ck, s_tx, ck_in, rx_in;
	logic [7:0]       a_dir, a_dat, a_pu, a_odr, b_dir, b_dat, junk;
	logic [39:0]      q_v[$], q_m[$];
	logic [31:0]      r;
	integer           seed, errors = 0, n_compared = 0;

	always #10 clk_sys = ~clk_sys;

	iopab_port DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pa_in(pa_in), .pa_out(pa_out),
		.pa_oe(pa_oe), .pa_pullup(pa_pullup), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
		.shutdown_in_enable(sd_en), .clock_pin_mode_hi(ck_hi), .clock_pin_mode_lo(ck_lo),
		.serial2_sync_mode(sync_m), .rx_path_on(rx_on), .tx_path_on(tx_on),
		.serial2_clock_out(s_ck), .serial2_tx_data(s_tx), .serial2_clock_in(ck_in),
		.serial2_rx_data(rx_in), .shutdown_in(sd_in));
	iopab_board #(.W(4)) board_a (.clk_sys(clk_sys), .dev_out(pa_out), .dev_oe(pa_oe),
		.pull_en(pa_pullup), .ext_val(ext_a), .ext_en(ext_a_en), .level(pa_in));
	iopab_board #(.W(8)) board_b (.clk_sys(clk_sys), .dev_out(pb_out), .dev_oe(pb_oe),
		.pull_en(8'h00), .ext_val(ext_b), .ext_en(8'hFF), .level(pb_in));

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic wr_rand(input logic [2:0] a, output logic [7:0] v);
		logic [31:0] t;
		t = $random(seed);
		v = t[7:0];
		wr(a, v);
	endtask : wr_rand

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		q_v.push_back({32'h0, e});
		q_m.push_back(40'hFF);
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
	endtask : rd

	task automatic snap(input logic [39:0] v, input logic [39:0] m);
		@(posedge clk_sys);
		smp <= 1'b1;
		q_v.push_back(v);
		q_m.push_back(m);
		@(posedge clk_sys);
		smp <= 1'b0;
	endtask : snap

	// Expected pins follow the function priority, then the output type of each driving pin.
	task automatic check_all;
		logic [3:0] io, d, oe, o, pu, lv, sdi;
		logic       cki, rxd;
		io = a_dir[3:0];
		d  = a_dat[3:0];
		if (sd_en[3] | ck_hi) io[3] = 1'b0;
		else if (sync_m | ck_lo) begin
			io[3] = 1'b1;
			d[3]  = s_ck;
		end
		if (sd_en[2] | rx_on) io[2] = 1'b0;
		if (sd_en[1]) io[1] = 1'b0;
		else if (tx_on) begin
			io[1] = 1'b1;
			d[1]  = s_tx;
		end
		if (sd_en[0]) io[0] = 1'b0;
		oe  = io & ~(a_odr[3:0] & d);
		o   = d & ~a_odr[3:0];
		pu  = ~io & a_pu[3:0];
		lv  = (oe & o) | (~oe & ((ext_a_en & ext_a) | (~ext_a_en & pu)));
		cki = (!sd_en[3] && ck_hi) ? lv[3] : 1'b1;
		rxd = (!sd_en[2] && rx_on) ? lv[2] : 1'b1;
		sdi = (sd_en & lv) | ~sd_en;
		snap({6'h0, cki, rxd, sdi, pu, oe, o, b_dir, b_dat},
			{6'h0, 2'h3, 4'hF, 4'hF, 4'hF, io, 8'hFF, b_dir});
		rd(OFS_PA_OUTPUT_TYPE, {4'h0, a_odr[3:0]});
		rd(OFS_PA_OUTPUT_DATA, {4'h0, a_dat[3:0]});
		rd(OFS_PA_PULLUP_CTRL, {4'h0, a_pu[3:0]});
		rd(OFS_PA_DIRECTION, READ_UNDEF);
		rd(OFS_PA_PIN_STATE, {4'h0, (a_dir[3:0] & a_dat[3:0]) | (~a_dir[3:0] & lv)});
		rd(OFS_PB_DIRECTION, READ_UNDEF);
		rd(OFS_PB_OUTPUT_DATA, b_dat);
		rd(OFS_PB_PIN_STATE, (b_dir & b_dat) | (~b_dir & ext_b));
	endtask : check_all

	always @(posedge clk_sys) begin
		rd_d  <= reg_rd;
		smp_d <= smp;
	end

	// Results are compared mid-cycle, once every edge's updates have landed.
	always @(negedge clk_sys) begin
		logic [39:0] obs, ev, em;
		if (rd_d | smp_d) begin
			obs = rd_d ? {32'h0, reg_rdata}
				: {6'h0, ck_in, rx_in, sd_in, pa_pullup, pa_oe, pa_out, pb_oe, pb_out};
			ev  = 40'h0;
			em  = 40'hFF_FFFF_FFFF;
			if (q_v.size() != 0) begin
				ev = q_v.pop_front();
				em = q_m.pop_front();
			end
			n_compared = n_compared + 1;
			if (((obs ^ ev) & em) !== 40'h0) begin
				errors = errors + 1;
				$display("CHECK FAILED at %0t got %h expected %h", $time, obs, ev);
			end
		end
	end

	initial begin
		idle(20000);
		errors = errors + 1;
		$display("CHECK FAILED at %0t got %h expected %h", $time, 1'b0, 1'b1);
		print_verdict();
	end

	initial begin
		seed = 41;
		{nrst, reg_wr, reg_rd, smp, reg_addr, reg_wdata} = '0;
		{sd_en, ck_hi, ck_lo, sync_m, rx_on, tx_on, s_ck, s_tx, ext_a, ext_b} = '0;
		{a_dir, a_dat, a_pu, a_odr, b_dir, b_dat} = '0;
		ext_a_en = 4'hF;
		idle(2);
		nrst <= 1'b1;
		idle(6);
		check_all();
		$display("test reset done");
		for (int k = 0; k < 48; k++) begin
			wr_rand(OFS_PA_DIRECTION, a_dir);
			wr_rand(OFS_PA_OUTPUT_DATA, a_dat);
			wr_rand(OFS_PA_PULLUP_CTRL, a_pu);
			wr_rand(OFS_PA_OUTPUT_TYPE, a_odr);
			wr_rand(OFS_PB_DIRECTION, b_dir);
			wr_rand(OFS_PB_OUTPUT_DATA, b_dat);
			wr_rand(OFS_PB_PIN_STATE, junk);
			wr_rand(OFS_PA_PIN_STATE, junk);
			r = $random(seed);
			sd_en <= r[3:0] & r[7:4];
			{ck_hi, ck_lo, sync_m, rx_on, tx_on, s_ck, s_tx} <= r[14:8];
			ext_a <= r[19:16];
			ext_b <= r[27:20];
			idle(6);
			check_all();
		end
		$display("test random done");
		a_dir = 8'h00;
		a_pu  = 8'h0F;
		wr(OFS_PA_DIRECTION, a_dir);
		wr(OFS_PA_PULLUP_CTRL, a_pu);
		{sd_en, ck_hi, ck_lo, sync_m, rx_on, tx_on} <= '0;
		ext_a_en <= 4'h0;
		idle(6);
		check_all();
		ext_a_en <= 4'hF;
		$display("test pull-up done");
		@(posedge clk_sys);
		nrst <= 1'b0;
		{a_dir, a_dat, a_pu, a_odr, b_dir, b_dat} = '0;
		idle(2);
		nrst <= 1'b1;
		idle(6);
		check_all();
		$display("test second reset done");
		print_verdict();
	end
endmodule : tb
